// ### verilog/cact_consts.svh
// Register indices, field positions, reset values and counts for the channel control block
`ifndef CACT_CONSTS_SVH
`define CACT_CONSTS_SVH
// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define CACT_IDX_LINE_CFG     6'h06
`define CACT_IDX_ALARM_CTL    6'h08
`define CACT_IDX_TX_RESET     6'h09
`define CACT_IDX_LABEL_TRACE  6'h10
`define CACT_IDX_IRQ_STATUS   6'h14
`define CACT_IDX_IRQ_MASK     6'h15
`define CACT_IDX_LIVE_STATE   6'h16
`define CACT_IDX_COUNTERS     6'h17
// ----------------------------------------
// Writable bit masks and reset values
// ----------------------------------------
`define CACT_LINE_CFG_MASK    8'hcf
`define CACT_ALARM_CTL_MASK   8'h1f
`define CACT_TX_RESET_MASK    8'h01
`define CACT_LABEL_MASK       8'h3f
`define CACT_IRQ_MASK_BITS    8'h07
`define CACT_REG_RESET        8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CACT_LINE_IF_HI       7
`define CACT_LINE_IF_LO       6
`define CACT_RDI_SINGLE       3
`define CACT_DROP_SIDE        2
`define CACT_ROUTE_HI         1
`define CACT_ROUTE_LO         0
`define CACT_OVH_CLK_SEL      4
`define CACT_RDI_AUTO_EN      3
`define CACT_TC_AUTO_EN       2
`define CACT_AIS_AUTO_EN      1
`define CACT_AIS_FORCE        0
`define CACT_TANDEM_EN        5
`define CACT_LABEL_HI         4
`define CACT_LABEL_LO         2
`define CACT_IRQ_LABEL        0
`define CACT_IRQ_ALARM        1
`define CACT_IRQ_RESET        2
// ----------------------------------------
// Counter presets, bus answers, clock divider
// ----------------------------------------
`define CACT_SAT_CLEAR        8'h00
`define CACT_NSAT8_PRESET     8'hfe
`define CACT_NSAT16_PRESET    16'hfffe
`define CACT_SAT_MAX          8'hff
`define CACT_RESP_OKAY        2'b00
`define CACT_RESP_SLVERR      2'b10
`define CACT_LINE_IF_VT       2'b11
`define CACT_TRIB_HALF_DIV    16
`endif

// ### verilog/cact_pkg.sv
// Types shared by the channel control block
package cact_pkg;
   typedef enum logic [1:0] {
      CACT_ROUTE_DROP = 2'b00,
      CACT_ROUTE_SAME = 2'b01,
      CACT_ROUTE_MUX  = 2'b10,
      CACT_ROUTE_DUAL = 2'b11
   } cact_route_t;
   typedef enum logic [1:0] {
      CACT_J2_16_ROT   = 2'b00,
      CACT_J2_16_ALIGN = 2'b01,
      CACT_J2_64_ROT   = 2'b10,
      CACT_J2_64_CRLF  = 2'b11
   } cact_j2_mode_t;
endpackage

// ### verilog/cact_top.sv
// Channel alarm action, routing, label and trace mode control with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "cact_consts.svh"
module cact_top #(
   parameter int TRIB_HALF_DIV = `CACT_TRIB_HALF_DIV
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // Drop side status
   input  wire logic        drop_alarm_a,
   input  wire logic        drop_alarm_b,
   input  wire logic        ovh_byte_time,
   input  wire logic [7:0]  v5_byte,
   input  wire logic        v5_valid,
   // Add side events
   input  wire logic        add_frame_tick,
   input  wire logic        add_error,
   // Receive actions
   output logic             rx_tributary_out_clock,
   output logic             rx_ovh_shift_out,
   output logic             rdi_auto,
   output logic             rdi_single_form,
   output logic             tc_rdi_auto,
   output logic             tc_odi_auto,
   output logic             line_ais_out,
   // Routing, trace and label
   output logic             drop_from_b,
   output logic             add_to_a,
   output logic             add_to_b,
   output logic             tandem_active,
   output logic             trace_len64,
   output logic             trace_aligned,
   output logic             trace_compare,
   output logic             label_mismatch,
   // Add side init and interrupt
   output logic             add_init_pulse,
   output logic             irq
);
   // ----------------------------------------
   // Registers and bus decode
   // ----------------------------------------
   logic [7:0]  line_cfg_r, alarm_ctl_r, tx_reset_r, label_r, irq_stat_r, irq_mask_r;
   logic [7:0]  sat_cnt_r, nsat8_r;
   logic [15:0] nsat16_r;
   logic        aw_rdy_r, b_vld_r, ar_rdy_r, r_vld_r;
   logic [1:0]  b_resp_r, r_resp_r;
   logic [31:0] r_data_r;
   logic        mismatch_r, alarm_d_r, init_r;
   logic [15:0] div_cnt_r;
   logic        trib_clk_r, ovh_shift_r, rdi_r, single_r, tc_rdi_r, tc_odi_r, ais_r;
   logic        from_b_r, add_a_r, add_b_r, tc_act_r, len64_r, align_r, cmp_r, irq_r;
   wire         wr_go    = aw_rdy_r & s_awvalid & s_wvalid;
   wire [5:0]   wr_idx   = s_awaddr[7:2];
   wire [5:0]   rd_idx   = s_araddr[7:2];
   wire [7:0]   wd       = s_wdata[7:0];
   wire         wr_lane  = wr_go & s_wstrb[0];
   wire         we_line  = wr_lane & (wr_idx == `CACT_IDX_LINE_CFG);
   wire         we_alarm = wr_lane & (wr_idx == `CACT_IDX_ALARM_CTL);
   wire         we_rst   = wr_lane & (wr_idx == `CACT_IDX_TX_RESET);
   wire         we_label = wr_lane & (wr_idx == `CACT_IDX_LABEL_TRACE);
   wire         we_stat  = wr_lane & (wr_idx == `CACT_IDX_IRQ_STATUS);
   wire         we_mask  = wr_lane & (wr_idx == `CACT_IDX_IRQ_MASK);
   wire         wr_hit   = (wr_idx == `CACT_IDX_LINE_CFG) | (wr_idx == `CACT_IDX_ALARM_CTL) |
                           (wr_idx == `CACT_IDX_TX_RESET) | (wr_idx == `CACT_IDX_LABEL_TRACE) |
                           (wr_idx == `CACT_IDX_IRQ_STATUS) | (wr_idx == `CACT_IDX_IRQ_MASK) |
                           (wr_idx == `CACT_IDX_LIVE_STATE) | (wr_idx == `CACT_IDX_COUNTERS);
   wire         rd_go    = ar_rdy_r & s_arvalid;
   wire [7:0]   live     = {1'b0, init_r, tc_act_r, ais_r, tc_rdi_r, rdi_r, alarm_d_r, mismatch_r};
   logic [31:0] rd_mux;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h00000000;
      unique case (rd_idx)
         `CACT_IDX_LINE_CFG:    rd_mux = {24'h000000, line_cfg_r};
         `CACT_IDX_ALARM_CTL:   rd_mux = {24'h000000, alarm_ctl_r};
         `CACT_IDX_TX_RESET:    rd_mux = {24'h000000, tx_reset_r};
         `CACT_IDX_LABEL_TRACE: rd_mux = {24'h000000, label_r};
         `CACT_IDX_IRQ_STATUS:  rd_mux = {24'h000000, irq_stat_r};
         `CACT_IDX_IRQ_MASK:    rd_mux = {24'h000000, irq_mask_r};
         `CACT_IDX_LIVE_STATE:  rd_mux = {24'h000000, live};
         `CACT_IDX_COUNTERS:    rd_mux = {nsat16_r, nsat8_r, sat_cnt_r};
         default:               rd_hit = 1'b0;
      endcase
   end
   // ----------------------------------------
   // AXI4-Lite handshakes
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_r <= 1'b0;
         b_vld_r  <= 1'b0;
         b_resp_r <= `CACT_RESP_OKAY;
         ar_rdy_r <= 1'b0;
         r_vld_r  <= 1'b0;
         r_resp_r <= `CACT_RESP_OKAY;
         r_data_r <= 32'h00000000;
      end else begin
         aw_rdy_r <= s_awvalid & s_wvalid & ~aw_rdy_r & ~b_vld_r;
         if (wr_go) begin
            b_vld_r  <= 1'b1;
            b_resp_r <= wr_hit ? `CACT_RESP_OKAY : `CACT_RESP_SLVERR;
         end else if (s_bready)
            b_vld_r <= 1'b0;
         ar_rdy_r <= s_arvalid & ~ar_rdy_r & ~r_vld_r;
         if (rd_go) begin
            r_vld_r  <= 1'b1;
            r_data_r <= rd_mux;
            r_resp_r <= rd_hit ? `CACT_RESP_OKAY : `CACT_RESP_SLVERR;
         end else if (s_rready)
            r_vld_r <= 1'b0;
      end
   end
   // ----------------------------------------
   // Control registers and decoded controls
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_cfg_r  <= `CACT_REG_RESET;
         alarm_ctl_r <= `CACT_REG_RESET;
         tx_reset_r  <= `CACT_REG_RESET;
         label_r     <= `CACT_REG_RESET;
         irq_mask_r  <= `CACT_REG_RESET;
      end else begin
         if (we_line)  line_cfg_r  <= wd & `CACT_LINE_CFG_MASK;
         if (we_alarm) alarm_ctl_r <= wd & `CACT_ALARM_CTL_MASK;
         if (we_rst)   tx_reset_r  <= wd & `CACT_TX_RESET_MASK;
         if (we_label) label_r     <= wd & `CACT_LABEL_MASK;
         if (we_mask)  irq_mask_r  <= wd & `CACT_IRQ_MASK_BITS;
      end
   end
   wire        vt_if    = line_cfg_r[`CACT_LINE_IF_HI:`CACT_LINE_IF_LO] == `CACT_LINE_IF_VT;
   wire        ovh_sel  = alarm_ctl_r[`CACT_OVH_CLK_SEL];
   wire        side_b   = line_cfg_r[`CACT_DROP_SIDE];
   wire cact_pkg::cact_route_t route =
      cact_pkg::cact_route_t'(line_cfg_r[`CACT_ROUTE_HI:`CACT_ROUTE_LO]);
   wire cact_pkg::cact_j2_mode_t j2 = cact_pkg::cact_j2_mode_t'(label_r[1:0]);
   wire        sel_alarm = side_b ? drop_alarm_b : drop_alarm_a;
   wire        gap_now   = vt_if & ~ovh_sel & ovh_byte_time;
   wire        rst_go    = we_rst & wd[0];
   wire        div_end   = div_cnt_r == 16'(TRIB_HALF_DIV - 1);
   wire        tc_ok     = label_r[`CACT_TANDEM_EN] & ~label_r[1];
   // ----------------------------------------
   // Receive actions, routing, trace and label
   // ----------------------------------------
   // Clock held low through overhead times instead of stretched, so payload rate is kept
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r   <= 16'h0000;
         trib_clk_r  <= 1'b0;
         ovh_shift_r <= 1'b0;
         rdi_r       <= 1'b0;
         single_r    <= 1'b0;
         tc_rdi_r    <= 1'b0;
         tc_odi_r    <= 1'b0;
         ais_r       <= 1'b0;
      end else begin
         div_cnt_r   <= div_end ? 16'h0000 : div_cnt_r + 16'h0001;
         if (gap_now)
            trib_clk_r <= 1'b0;
         else if (div_end & vt_if)
            trib_clk_r <= ~trib_clk_r;
         ovh_shift_r <= vt_if & ovh_sel;
         rdi_r       <= alarm_ctl_r[`CACT_RDI_AUTO_EN] & sel_alarm;
         single_r    <= line_cfg_r[`CACT_RDI_SINGLE];
         tc_rdi_r    <= alarm_ctl_r[`CACT_TC_AUTO_EN] & sel_alarm & tc_ok;
         tc_odi_r    <= alarm_ctl_r[`CACT_TC_AUTO_EN] & sel_alarm & tc_ok;
         ais_r       <= alarm_ctl_r[`CACT_AIS_FORCE] |
                        (alarm_ctl_r[`CACT_AIS_AUTO_EN] & sel_alarm);
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         from_b_r   <= 1'b0;
         add_a_r    <= 1'b0;
         add_b_r    <= 1'b0;
         tc_act_r   <= 1'b0;
         len64_r    <= 1'b0;
         align_r    <= 1'b0;
         cmp_r      <= 1'b0;
         mismatch_r <= 1'b0;
      end else begin
         from_b_r <= side_b;
         add_a_r  <= (route == cact_pkg::CACT_ROUTE_DUAL) |
                     ((route == cact_pkg::CACT_ROUTE_SAME) & ~side_b) |
                     ((route == cact_pkg::CACT_ROUTE_MUX) & side_b);
         add_b_r  <= (route == cact_pkg::CACT_ROUTE_DUAL) |
                     ((route == cact_pkg::CACT_ROUTE_SAME) & side_b) |
                     ((route == cact_pkg::CACT_ROUTE_MUX) & ~side_b);
         tc_act_r <= tc_ok;
         len64_r  <= label_r[1];
         align_r  <= j2 == cact_pkg::CACT_J2_16_ALIGN | j2 == cact_pkg::CACT_J2_64_CRLF;
         cmp_r    <= j2 == cact_pkg::CACT_J2_16_ALIGN;
         if (v5_valid)
            mismatch_r <= label_r[`CACT_LABEL_HI:`CACT_LABEL_LO] != v5_byte[3:1];
      end
   end
   // ----------------------------------------
   // Add side counters, init and interrupts
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sat_cnt_r <= `CACT_SAT_CLEAR;
         nsat8_r   <= `CACT_NSAT8_PRESET;
         nsat16_r  <= `CACT_NSAT16_PRESET;
         init_r    <= 1'b0;
      end else begin
         init_r <= rst_go;
         if (rst_go) begin
            sat_cnt_r <= `CACT_SAT_CLEAR;
            nsat8_r   <= `CACT_NSAT8_PRESET;
            nsat16_r  <= `CACT_NSAT16_PRESET;
         end else begin
            if (add_error && sat_cnt_r != `CACT_SAT_MAX)
               sat_cnt_r <= sat_cnt_r + 8'h01;
            if (add_frame_tick) begin
               nsat8_r  <= nsat8_r + 8'h01;
               nsat16_r <= nsat16_r + 16'h0001;
            end
         end
      end
   end
   wire [7:0] irq_evt = {5'h00, init_r, sel_alarm & ~alarm_d_r,
                         v5_valid & ~mismatch_r &
                         (label_r[`CACT_LABEL_HI:`CACT_LABEL_LO] != v5_byte[3:1])};
   // A new event in the clearing cycle survives the write-one-to-clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= `CACT_REG_RESET;
         alarm_d_r  <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         alarm_d_r  <= sel_alarm;
         irq_stat_r <= (irq_stat_r & ~(we_stat ? wd : 8'h00)) | irq_evt;
         irq_r      <= |(irq_stat_r & irq_mask_r);
      end
   end
   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_awready = aw_rdy_r;
   assign s_wready  = aw_rdy_r;
   assign s_bvalid  = b_vld_r;
   assign s_bresp   = b_resp_r;
   assign s_arready = ar_rdy_r;
   assign s_rvalid  = r_vld_r;
   assign s_rresp   = r_resp_r;
   assign s_rdata   = r_data_r;
   assign rx_tributary_out_clock = trib_clk_r;
   assign rx_ovh_shift_out       = ovh_shift_r;
   assign rdi_auto               = rdi_r;
   assign rdi_single_form        = single_r;
   assign tc_rdi_auto            = tc_rdi_r;
   assign tc_odi_auto            = tc_odi_r;
   assign line_ais_out           = ais_r;
   assign drop_from_b            = from_b_r;
   assign add_to_a               = add_a_r;
   assign add_to_b               = add_b_r;
   assign tandem_active          = tc_act_r;
   assign trace_len64            = len64_r;
   assign trace_aligned          = align_r;
   assign trace_compare          = cmp_r;
   assign label_mismatch         = mismatch_r;
   assign add_init_pulse         = init_r;
   assign irq                    = irq_r;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_gap_clock_low:   assert property (gap_now |=> !trib_clk_r)
      else $error("tributary clock not gapped");
   a_sym_ovh_out:     assert property (vt_if && ovh_sel |=> ovh_shift_r)
      else $error("overhead not shifted");
   a_rdi_auto_gate:   assert property (rdi_r |-> $past(alarm_ctl_r[`CACT_RDI_AUTO_EN] && sel_alarm))
      else $error("rdi without cause");
   a_tc_needs_16:     assert property ((tc_rdi_r || tc_odi_r) |-> !len64_r)
      else $error("tandem active in 64 mode");
   a_ais_force_now:   assert property (alarm_ctl_r[`CACT_AIS_FORCE] |=> ais_r)
      else $error("forced ais missing");
   a_ais_auto_gate:   assert property (alarm_ctl_r[`CACT_AIS_AUTO_EN] && sel_alarm |=> ais_r)
      else $error("auto ais missing");
   a_reset_presets:   assert property (rst_go |=> nsat8_r == `CACT_NSAT8_PRESET &&
                                       sat_cnt_r == `CACT_SAT_CLEAR && nsat16_r == `CACT_NSAT16_PRESET)
      else $error("counter presets wrong");
   a_reset_keeps_cfg: assert property (rst_go |=> $stable(alarm_ctl_r) && $stable(line_cfg_r))
      else $error("control bits changed");
   a_label_compare:   assert property (v5_valid |=> mismatch_r ==
                                       ($past(label_r[4:2]) != $past(v5_byte[3:1])))
      else $error("label compare wrong");
   a_route_dual:      assert property (route == cact_pkg::CACT_ROUTE_DUAL |=> add_a_r && add_b_r)
      else $error("dual ring routing wrong");
   a_unused_zero:     assert property (alarm_ctl_r[7:5] == 3'h0 && label_r[7:6] == 2'h0)
      else $error("unused bits set");
   c_write_done:  cover property (wr_go ##1 b_vld_r);
   c_read_done:   cover property (rd_go ##1 r_vld_r);
   c_gap_seen:    cover property (gap_now ##1 !trib_clk_r);
   c_irq_raised:  cover property (irq_r);
endmodule
`default_nettype wire

// ### sim/cact_bus_model.sv
// Far-side drop and add bus model feeding alarms, overhead timing and V5 bytes
`timescale 1ns/100ps
`default_nettype none
module cact_bus_model (
   // Clock
   input  wire logic       aclk,
   // Drop side status
   output logic            drop_alarm_a,
   output logic            drop_alarm_b,
   output logic            ovh_byte_time,
   output logic [7:0]      v5_byte,
   output logic            v5_valid,
   // Add side events
   output logic            add_frame_tick,
   output logic            add_error
);
   initial begin
      {drop_alarm_a, drop_alarm_b, ovh_byte_time, v5_valid} = 4'h0;
      {add_frame_tick, add_error} = 2'b00;
      v5_byte = 8'h55;
   end
   // Drop bus is the receive source
   // Never inserts RDI, tandem RDI/ODI or AIS itself
   task automatic alarms(input logic a, input logic b);
      drop_alarm_a <= a;
      drop_alarm_b <= b;
      @(posedge aclk);
   endtask
   task automatic ovh(input logic v);
      ovh_byte_time <= v;
      @(posedge aclk);
   endtask
   task automatic v5(input logic [7:0] d);
      v5_byte  <= d;
      v5_valid <= 1'b1;
      @(posedge aclk);
      v5_valid <= 1'b0;
      // Byte is stale after the strobe
      v5_byte  <= ~d;
      @(posedge aclk);
   endtask
   task automatic pulse(input logic f, input logic e);
      add_frame_tick <= f;
      add_error      <= e;
      @(posedge aclk);
      {add_frame_tick, add_error} <= 2'b00;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ### sim/channel_alarm_action_control_test.sv
// Self-checking bench for the channel control block
`timescale 1ns/100ps
`default_nettype none
module channel_alarm_action_control_test;
   logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic [7:0]  s_awaddr, s_araddr, v5_byte;
   logic [31:0] s_wdata, s_rdata;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp;
   logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, drop_alarm_a, drop_alarm_b;
   logic        ovh_byte_time, v5_valid, add_frame_tick, add_error, rx_tributary_out_clock;
   logic        rx_ovh_shift_out, rdi_auto, rdi_single_form, tc_rdi_auto, tc_odi_auto, line_ais_out;
   logic        drop_from_b, add_to_a, add_to_b, tandem_active, trace_len64, trace_aligned;
   logic        trace_compare, label_mismatch, add_init_pulse, irq;
   logic [2:0]  q;
   int          fail_count, checks, hi, pulses, p0;
   cact_top #(.TRIB_HALF_DIV(2)) u_dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
      .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .drop_alarm_a, .drop_alarm_b, .ovh_byte_time, .v5_byte,
      .v5_valid, .add_frame_tick, .add_error, .rx_tributary_out_clock, .rx_ovh_shift_out, .rdi_auto,
      .rdi_single_form, .tc_rdi_auto, .tc_odi_auto, .line_ais_out, .drop_from_b, .add_to_a, .add_to_b,
      .tandem_active, .trace_len64, .trace_aligned, .trace_compare, .label_mismatch, .add_init_pulse, .irq);
   cact_bus_model u_far (.aclk, .drop_alarm_a, .drop_alarm_b, .ovh_byte_time, .v5_byte, .v5_valid,
      .add_frame_tick, .add_error);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   always @(posedge aclk) if (add_init_pulse === 1'b1) pulses++;
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done  = 1'b0;
      {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'b111};
      // Each channel released at its own handshake
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_awready === 1'b1 && !aw_done) begin
            s_awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (s_wready === 1'b1 && !w_done) begin
            s_wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      do @(posedge aclk); while (s_bvalid !== 1'b1);
      s_bready <= 1'b0;
      chk("bresp", er, s_bresp);
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      {s_araddr, s_arvalid, s_rready} <= {a, 2'b11};
      do @(posedge aclk); while (s_arready !== 1'b1);
      s_arvalid <= 1'b0;
      do @(posedge aclk); while (s_rvalid !== 1'b1);
      s_rready <= 1'b0;
      chk("rresp", er, s_rresp);
      chk("rdata", e, s_rdata);
      @(posedge aclk);
   endtask
   task automatic wc(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, 2'b00);
      repeat (3) @(posedge aclk);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      // Margin of more than twenty times the expected run
      #200000;
      fail_count++;
      end_sim();
   end
   initial begin
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h00;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = {16'h0, 32'h0, 4'hf};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h20, 32'h0, 2'b00);
      rd(8'h24, 32'h0, 2'b00);
      rd(8'h40, 32'h0, 2'b00);
      wr(8'h20, 32'hffffffff, 2'b00);
      rd(8'h20, 32'h1f, 2'b00);
      wr(8'h40, 32'hff, 2'b00);
      rd(8'h40, 32'h3f, 2'b00);
      wr(8'h7c, 32'h1, 2'b10);
      rd(8'h7c, 32'h0, 2'b10);
      $display("test registers done");
      for (int r = 0; r < 8; r++) begin
         q = r[2:0];
         wc(8'h18, r);
         chk("route", {q[2], q[1] & q[0] | (q[1] ^ q[0]) & (q[1] == q[2]), q[1] & q[0] | (q[1] ^ q[0]) &
            (q[1] != q[2])}, {drop_from_b, add_to_a, add_to_b});
      end
      $display("test routing done");
      wc(8'h18, 32'h08);
      wc(8'h40, 32'h20);
      wc(8'h20, 32'h0e);
      u_far.alarms(1'b0, 1'b1);
      repeat (3) @(posedge aclk);
      chk("alarm b", 4'h0, {rdi_auto, tc_rdi_auto, tc_odi_auto, line_ais_out});
      u_far.alarms(1'b1, 1'b0);
      repeat (3) @(posedge aclk);
      chk("alarm a", 5'h1f, {rdi_auto, rdi_single_form, tc_rdi_auto, tc_odi_auto, line_ais_out});
      wc(8'h20, 32'h00);
      chk("alarm off", 4'h0, {rdi_auto, tc_rdi_auto, tc_odi_auto, line_ais_out});
      u_far.alarms(1'b0, 1'b0);
      wc(8'h20, 32'h01);
      chk("force ais", 4'h1, {rdi_auto, tc_rdi_auto, tc_odi_auto, line_ais_out});
      $display("test alarms done");
      for (int m = 0; m < 4; m++) begin
         wc(8'h40, 32'h20 | m);
         chk("trace", {~m[1], m[1], m[0], m == 1}, {tandem_active, trace_len64, trace_aligned,
            trace_compare});
      end
      $display("test trace modes done");
      wc(8'h40, 32'h14);
      wc(8'h50, 32'h07);
      wc(8'h54, 32'h01);
      u_far.v5(8'h0a);
      repeat (3) @(posedge aclk);
      chk("label match", 2'b00, {label_mismatch, irq});
      u_far.v5(8'h08);
      repeat (3) @(posedge aclk);
      chk("label differ", 2'b11, {label_mismatch, irq});
      rd(8'h50, 32'h1, 2'b00);
      wc(8'h50, 32'h01);
      chk("irq clear", 1'b0, irq);
      $display("test label done");
      u_far.pulse(1'b1, 1'b1);
      u_far.pulse(1'b1, 1'b0);
      rd(8'h5c, 32'h00000001, 2'b00);
      p0 = pulses;
      wc(8'h24, 32'h01);
      chk("init pulse", p0 + 1, pulses);
      rd(8'h5c, 32'hfffefe00, 2'b00);
      rd(8'h40, 32'h14, 2'b00);
      s_wstrb <= 4'he;
      wr(8'h40, 32'h00, 2'b00);
      s_wstrb <= 4'hf;
      rd(8'h40, 32'h14, 2'b00);
      $display("test transmit reset done");
      wc(8'h18, 32'hc0);
      for (int k = 0; k < 3; k++) begin
         u_far.ovh(k < 2);
         wc(8'h20, (k & 1) << 4);
         hi = 0;
         repeat (8) begin
            @(posedge aclk);
            hi += rx_tributary_out_clock;
         end
         chk("trib clock", (k == 0) ? 0 : 4, hi);
         chk("ovh shift", k == 1, rx_ovh_shift_out);
      end
      $display("test tributary clock done");
      end_sim();
   end
endmodule
`default_nettype wire
